// ---- common/ams_pkg.sv ----
// Scheduler constants
package ams_pkg;
   localparam int ADDR_W = 6;
   localparam int PADDR_W = 5;
   // Host register offsets
   localparam logic [5:0] REG_IRQ_ENABLE = 6'h03;
   localparam logic [5:0] REG_WAKE_INTERVAL = 6'h08;
   localparam logic [5:0] REG_PS_THRESH_LO = 6'h10;
   localparam logic [5:0] REG_PS_THRESH_HI = 6'h11;
   localparam logic [5:0] REG_ALS_THRESH_LO = 6'h12;
   localparam logic [5:0] REG_ALS_THRESH_HI = 6'h13;
   localparam logic [5:0] REG_PARAM_WR = 6'h17;
   localparam logic [5:0] REG_COMMAND = 6'h18;
   localparam logic [5:0] REG_RESPONSE = 6'h20;
   localparam logic [5:0] REG_IRQ_FLAGS = 6'h21;
   localparam logic [5:0] REG_RESULT_BASE = 6'h22;
   localparam logic [5:0] REG_RESULT_END = 6'h2e;
   localparam logic [5:0] REG_PARAM_RD = 6'h2e;
   localparam logic [5:0] REG_SEQ_STATE = 6'h30;
   // Parameter memory locations
   localparam logic [4:0] PARAM_CHANNEL_LIST = 5'h01;
   localparam logic [4:0] PARAM_PS_DIVIDER = 5'h0a;
   localparam logic [4:0] PARAM_ALS_DIVIDER = 5'h0b;
   localparam logic [4:0] PARAM_NO_SLEEP = 5'h1b;
   localparam logic [7:0] NO_SLEEP_ON = 8'h01;
   localparam logic [7:0] NO_SLEEP_OFF = 8'h81;
   // Reset values
   localparam logic [7:0] CHANNEL_LIST_RESET = 8'h00;
   localparam logic [7:0] DIVIDER_RESET = 8'h01;
   localparam logic [7:0] WAKE_INTERVAL_RESET = 8'h00;
   localparam logic [7:0] COUNTER_LOAD = 8'h01;
   // Commands
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h01;
   localparam logic [7:0] CMD_PS_FORCE = 8'h05;
   localparam logic [7:0] CMD_ALS_FORCE = 8'h06;
   localparam logic [7:0] CMD_BOTH_FORCE = 8'h07;
   localparam logic [7:0] CMD_PS_PAUSE = 8'h09;
   localparam logic [7:0] CMD_ALS_PAUSE = 8'h0a;
   localparam logic [7:0] CMD_BOTH_PAUSE = 8'h0b;
   localparam logic [7:0] CMD_PS_LOOP = 8'h0d;
   localparam logic [7:0] CMD_ALS_LOOP = 8'h0e;
   localparam logic [7:0] CMD_BOTH_LOOP = 8'h0f;
   localparam logic [2:0] OP_QUERY = 3'b100;
   localparam logic [2:0] OP_SET = 3'b101;
   localparam logic [2:0] OP_AND = 3'b110;
   localparam logic [7:0] RESP_INVALID = 8'h80;
   localparam logic [7:0] SEQ_READY = 8'h01;
   localparam logic [7:0] SEQ_BUSY = 8'h02;
   // Interrupt flag bits
   localparam int FLAG_ALS = 0;
   localparam int FLAG_PS = 2;
   localparam int WAKE_BASE_CYCLES = 800;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_PARAM = 3'b010,
      ST_ISSUE = 3'b011,
      ST_WAIT = 3'b100,
      ST_DONE = 3'b101
   } ams_state_t;
endpackage : ams_pkg

// ---- core/ams_param_ram.sv ----
// Parameter memory
`timescale 1ns/1ps
module ams_param_ram #(
   parameter int DEPTH_W = 5,
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic writeEn,
   input wire logic [DEPTH_W-1:0] writeAddr,
   input wire logic [WIDTH-1:0] writeData,
   input wire logic [DEPTH_W-1:0] readAddr,
   output logic [WIDTH-1:0] readData
);
   logic [WIDTH-1:0] mem [2**DEPTH_W];

   always_ff @(posedge core_clk) begin
      if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         readData <= '0;
      end else begin
         readData <= mem[readAddr];
      end
   end
endmodule : ams_param_ram

// ---- core/ams_group_counter.sv ----
// Per-group wake divider
`timescale 1ns/1ps
module ams_group_counter
   import ams_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic step,
   input wire logic [DIV_W-1:0] divider,
   output logic due
);
   logic [DIV_W-1:0] count;
   logic enabled;

   assign enabled = (divider != '0); // see R20
   assign due = step && enabled && (count <= DIV_W'(1)); // see R17

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= DIV_W'(COUNTER_LOAD);
      end else if (load) begin
         count <= DIV_W'(COUNTER_LOAD);
      end else if (step && enabled) begin
         count <= due ? divider : count - DIV_W'(1); // see R24
      end
   end
endmodule : ams_group_counter

// ---- core/ams_scheduler.sv ----
// Measurement scheduler core
`timescale 1ns/1ps
//
// Contract
// R1 - Loop start commands begin self-timed periodic measurement.
// R2 - Each result lands in its own 16-bit register.
// R3 - Polling host polls at twice the conversion rate.
// R4 - Host sets group rates, wake interval multiples, before loop start.
// R5 - Threshold crossing raises an interrupt flag.
// R6 - Map order: flags, ambient results, proximity results.
// R7 - Sleep between wakes unless no-sleep mode is set.
// R8 - Parameter 0x1B: 0x01 no-sleep, 0x81 sleeping.
// R9 - Wake only on timer expiry or command write at 0x18.
// R10 - Host keeps wake interval long enough after sleep entry.
// R11 - Host confirms previous command finished before another.
// R12 - Host stops loop by zero interval, waits two periods.
// R13 - Forced completion shows as non-zero interrupt flags.
// R14 - Register accesses do not wake; command writes do.
// R15 - Zero wake interval: forced mode, woken only by commands.
// R16 - Non-zero wake interval runs autonomously at that interval.
// R17 - Each wake steps separate proximity and ambient counters.
// R18 - Proximity group: enabled channels one, two, three in order.
// R19 - Ambient group: visible, infrared, auxiliary in order.
// R20 - Divider zero never runs the group; one runs it every wake.
// R21 - Proximity before ambient on a shared wake, then sleep.
// R22 - Host sets the channel enable list before measuring.
// R23 - Each successful command bumps a 4-bit wrapping reply counter. NOP and RESET clear it to zero instead.
// R24 - Group counters reload their divider after expiring.
module ams_scheduler
   import ams_pkg::*;
#(
   parameter int WAKE_BASE = WAKE_BASE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [ams_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic measStart,
   output logic [2:0] measChannel,
   input wire logic measDone,
   input wire logic [15:0] measData,
   output logic seqAwake,
   output logic intAsserted
);
   import ams_pkg::*;

   ams_state_t state;
   logic [7:0] command;
   logic [7:0] paramWr;
   logic [7:0] paramRd;
   logic [7:0] response;
   logic [7:0] wakeInterval;
   logic [7:0] irqEnable;
   logic [7:0] irqFlags;
   logic [15:0] psThresh;
   logic [15:0] alsThresh;
   logic [7:0] channel_enable_list;
   logic [7:0] psDivider;
   logic [7:0] alsDivider;
   logic noSleep;
   logic psLoop;
   logic alsLoop;
   logic cmdPending;
   logic wakePending;
   logic forcedRun;
   logic [5:0] pending;
   logic [2:0] curChan;
   logic [15:0] results [6];
   logic [$clog2(WAKE_BASE+1)-1:0] prescale;
   logic [7:0] tickCount;
   logic [7:0] ramData;

   // Slot order: vis, ir, aux, ps1, ps2, ps3
   function automatic logic [2:0] nextChan(input logic [5:0] m);
      nextChan = 3'h0;
      for (int k = 5; k >= 0; k--) begin
         if (m[(k + 3) % 6]) begin
            nextChan = 3'((k + 3) % 6); // see R18 see R19 see R21
         end
      end
   endfunction : nextChan

   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction : hit

   // Register decode
   wire cmdWrite = regWrite && hit(regAddr, REG_COMMAND);
   wire flagWrite = regWrite && hit(regAddr, REG_IRQ_FLAGS);
   wire inResults = (regAddr >= REG_RESULT_BASE) && (regAddr < REG_RESULT_END);
   wire [5:0] resultOff = regAddr - REG_RESULT_BASE;
   wire [2:0] resultSlot = resultOff[3:1];
   wire [15:0] resultWord = results[resultSlot];
   wire [7:0] resultByte = resultOff[0] ? resultWord[15:8] : resultWord[7:0];

   // Command fields
   wire [2:0] cmdOp = command[7:5];
   wire [4:0] cmdParam = command[4:0];
   wire isParamOp = command[7];
   // Divider and channel-list shadows answer from their registers, which carry reset values
   wire [7:0] ramView = (cmdParam == PARAM_PS_DIVIDER) ? psDivider :
                        (cmdParam == PARAM_ALS_DIVIDER) ? alsDivider :
                        (cmdParam == PARAM_CHANNEL_LIST) ? channel_enable_list : ramData;
   wire [7:0] paramNew = (cmdOp == OP_SET) ? paramWr :
                         (cmdOp == OP_AND) ? (ramView & paramWr) : (ramView | paramWr);
   wire [7:0] paramResult = (cmdOp == OP_QUERY) ? ramView : paramNew;
   wire paramStore = (state == ST_PARAM) && (cmdOp != OP_QUERY);

   // Channel masks from the enable list
   wire [5:0] psMask = {channel_enable_list[2:0], 3'b000};
   wire [5:0] alsMask = {3'b000, channel_enable_list[6:4]};

   // Wake timer
   wire autoOn = (psLoop || alsLoop) && (wakeInterval != 8'h00); // see R15 see R16
   wire prescaleEnd = (prescale == ($bits(prescale))'(WAKE_BASE - 1));
   wire wakeExpire = autoOn && prescaleEnd && (tickCount >= wakeInterval - 8'h01);
   wire timerTake = (state == ST_IDLE) && !cmdPending && wakePending; // see R9
   wire psDue;
   wire alsDue;
   wire [5:0] dueMask = (psDue ? psMask : 6'h00) | (alsDue ? alsMask : 6'h00);
   wire cmdTake = (state == ST_IDLE) && cmdPending;

   // Command decode
   wire inCmd = (state == ST_CMD) && !isParamOp;
   wire doReset = inCmd && (command == CMD_RESET);
   wire doNop = inCmd && (command == CMD_NOP);
   wire doForce = inCmd && (command >= CMD_PS_FORCE) && (command <= CMD_BOTH_FORCE);
   wire doPause = inCmd && (command >= CMD_PS_PAUSE) && (command <= CMD_BOTH_PAUSE);
   wire doLoop = inCmd && (command >= CMD_PS_LOOP) && (command <= CMD_BOTH_LOOP);
   wire cmdValid = doReset || doNop || doForce || doPause || doLoop;
   wire psSel = command[0];
   wire alsSel = command[1];
   wire loadPs = doLoop && psSel;
   wire loadAls = doLoop && alsSel;
   wire respInc = (doPause || doLoop) || (state == ST_PARAM) || (state == ST_DONE && forcedRun);

   // Result capture and event detection
   wire capture = (state == ST_WAIT) && measDone && !measStart;
   wire capPs = curChan >= 3'd3;
   wire [15:0] capThresh = capPs ? psThresh : alsThresh;
   wire capEvent = forcedRun || (measData > capThresh); // see R5 see R13
   wire [7:0] flagSet = (capture && capEvent) ?
                        (capPs ? (irqEnable & 8'h04) : (irqEnable & 8'h01)) : 8'h00;
   wire [7:0] flagClear = flagWrite ? regWdata : 8'h00;

   ams_group_counter #(.DIV_W(8)) u_psCounter (
      .core_clk(core_clk),
      .rstn(rstn),
      .load(loadPs),
      .step(timerTake && psLoop),
      .divider(psDivider),
      .due(psDue)
   );

   ams_group_counter #(.DIV_W(8)) u_alsCounter (
      .core_clk(core_clk),
      .rstn(rstn),
      .load(loadAls),
      .step(timerTake && alsLoop),
      .divider(alsDivider),
      .due(alsDue)
   );

   ams_param_ram #(.DEPTH_W(PADDR_W), .WIDTH(8)) u_paramRam (
      .core_clk(core_clk),
      .rstn(rstn),
      .writeEn(paramStore),
      .writeAddr(cmdParam),
      .writeData(paramNew),
      .readAddr(cmdParam),
      .readData(ramData)
   );

   // Awake outside idle or in no-sleep mode
   assign seqAwake = (state != ST_IDLE) || noSleep; // see R7 see R14
   assign intAsserted = |irqFlags; // see R13
   assign measChannel = curChan;

   // Host-written registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         command <= CMD_NOP;
         paramWr <= 8'h00;
         wakeInterval <= WAKE_INTERVAL_RESET;
         irqEnable <= 8'h00;
         psThresh <= 16'h0000;
         alsThresh <= 16'h0000;
      end else if (regWrite) begin
         unique case (regAddr)
            REG_COMMAND: command <= regWdata;
            REG_PARAM_WR: paramWr <= regWdata;
            REG_WAKE_INTERVAL: wakeInterval <= regWdata;
            REG_IRQ_ENABLE: irqEnable <= regWdata;
            REG_PS_THRESH_LO: psThresh[7:0] <= regWdata;
            REG_PS_THRESH_HI: psThresh[15:8] <= regWdata;
            REG_ALS_THRESH_LO: alsThresh[7:0] <= regWdata;
            REG_ALS_THRESH_HI: alsThresh[15:8] <= regWdata;
            default: ;
         endcase
      end
   end

   // Read data path
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= inResults ? resultByte :
                     (regAddr == REG_COMMAND) ? command :
                     (regAddr == REG_PARAM_WR) ? paramWr :
                     (regAddr == REG_WAKE_INTERVAL) ? wakeInterval :
                     (regAddr == REG_IRQ_ENABLE) ? irqEnable :
                     (regAddr == REG_RESPONSE) ? response :
                     (regAddr == REG_IRQ_FLAGS) ? irqFlags :
                     (regAddr == REG_PARAM_RD) ? paramRd :
                     (regAddr == REG_SEQ_STATE) ? (seqAwake && state != ST_IDLE ?
                                                   SEQ_BUSY : SEQ_READY) : 8'h00;
      end
   end

   // Pending wake sources; a new event wins over its own clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cmdPending <= 1'b0;
         wakePending <= 1'b0;
      end else begin
         cmdPending <= cmdWrite || (cmdPending && !cmdTake); // see R9 see R14
         wakePending <= autoOn && (wakeExpire || (wakePending && !timerTake));
      end
   end

   // Wake timer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prescale <= '0;
         tickCount <= 8'h00;
      end else if (!autoOn) begin
         prescale <= '0;
         tickCount <= 8'h00;
      end else if (prescaleEnd) begin
         prescale <= '0;
         tickCount <= wakeExpire ? 8'h00 : tickCount + 8'h01; // see R16
      end else begin
         prescale <= prescale + ($bits(prescale))'(1);
      end
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irqFlags <= 8'h00;
      end else begin
         irqFlags <= ((doReset ? 8'h00 : irqFlags) & ~flagClear) | flagSet; // see R5
      end
   end

   // Reply counter
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         response <= 8'h00;
      end else if (doNop || doReset) begin
         response <= 8'h00;
      end else if (inCmd && !cmdValid) begin
         response <= RESP_INVALID;
      end else if (respInc) begin
         response <= {4'h0, response[3:0] + 4'h1}; // see R23
      end
   end

   // Parameter shadows
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         paramRd <= 8'h00;
         channel_enable_list <= CHANNEL_LIST_RESET;
         psDivider <= DIVIDER_RESET;
         alsDivider <= DIVIDER_RESET;
         noSleep <= 1'b0;
      end else if (state == ST_PARAM) begin
         paramRd <= paramResult;
         if (paramStore) begin
            unique case (cmdParam)
               PARAM_CHANNEL_LIST: channel_enable_list <= paramNew;
               PARAM_PS_DIVIDER: psDivider <= paramNew;
               PARAM_ALS_DIVIDER: alsDivider <= paramNew;
               PARAM_NO_SLEEP: begin
                  if (paramNew == NO_SLEEP_ON || paramNew == NO_SLEEP_OFF) begin
                     noSleep <= (paramNew == NO_SLEEP_ON); // see R8
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Loop enables
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         psLoop <= 1'b0;
         alsLoop <= 1'b0;
      end else if (doReset) begin
         psLoop <= 1'b0;
         alsLoop <= 1'b0;
      end else if (doLoop || doPause) begin
         psLoop <= psSel ? doLoop : psLoop; // see R1
         alsLoop <= alsSel ? doLoop : alsLoop;
      end
   end

   // Results
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 6; i++) begin
            results[i] <= 16'h0000;
         end
      end else if (capture) begin
         results[curChan] <= measData; // see R2 see R6
      end
   end

   // Sequencer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         pending <= 6'h00;
         curChan <= 3'h0;
         forcedRun <= 1'b0;
         measStart <= 1'b0;
      end else begin
         measStart <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (cmdPending) begin
                  state <= ST_CMD;
               end else if (timerTake) begin
                  forcedRun <= 1'b0;
                  pending <= dueMask; // see R17
                  state <= (dueMask != 6'h00) ? ST_ISSUE : ST_IDLE;
               end
            end
            ST_CMD: begin
               if (isParamOp) begin
                  state <= ST_PARAM;
               end else if (doForce) begin
                  forcedRun <= 1'b1;
                  pending <= (psSel ? psMask : 6'h00) | (alsSel ? alsMask : 6'h00); // see R22
                  state <= ST_ISSUE;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_PARAM: state <= ST_IDLE;
            ST_ISSUE: begin
               if (pending == 6'h00) begin
                  state <= ST_DONE;
               end else begin
                  curChan <= nextChan(pending); // see R18 see R19 see R21
                  measStart <= 1'b1;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (capture) begin
                  pending[curChan] <= 1'b0;
                  state <= ST_ISSUE;
               end
            end
            ST_DONE: state <= ST_IDLE; // see R21
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule : ams_scheduler

// ---- tb/ams_monitor.sv ----
// Port checker for the measurement scheduler
`timescale 1ns/1ps
module ams_monitor (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [ams_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic measStart,
   input wire logic [2:0] measChannel,
   input wire logic measDone,
   input wire logic [15:0] measData,
   input wire logic seqAwake,
   input wire logic intAsserted
);
   import ams_pkg::*;
   // Rank puts proximity ahead of ambient
   logic [1:0] sinceDone;
   logic [2:0] prevRank;
   wire logic [2:0] curRank = (measChannel >= 3'h3) ? measChannel - 3'h3 : measChannel + 3'h3;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sinceDone <= 2'h3;
         prevRank <= 3'h0;
      end else begin
         sinceDone <= measDone ? 2'h0 : ((sinceDone == 2'h3) ? 2'h3 : sinceDone + 2'h1);
         if (measStart) begin
            prevRank <= curRank;
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_start_one_cycle: assert property (measStart |=> !measStart)
      else $error("start held too long");
   a_start_awake: assert property (measStart |-> seqAwake)
      else $error("start while asleep");
   a_cmd_wakes: assert property (regWrite && regAddr == REG_COMMAND |-> ##[1:4] seqAwake)
      else $error("command did not wake");
   a_group_order: assert property (measStart && sinceDone != 2'h3 |-> curRank > prevRank)
      else $error("channel order broken");
   a_unmapped_zero: assert property (regRead && regAddr == 6'h3f |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
      else $error("read data changed unread");
   a_int_after_done: assert property ($rose(intAsserted) |-> $past(measDone))
      else $error("interrupt without done");
   a_chan_stable: assert property (!measStart |-> $stable(measChannel))
      else $error("channel changed");
   cover property (measStart && measChannel == 3'h5);
   cover property ($rose(intAsserted));
   cover property (measStart && sinceDone != 2'h3 && curRank == 3'h3);
endmodule : ams_monitor

// ---- tb/ams_conv_model.sv ----
// Conversion front-end model
`timescale 1ns/1ps
module ams_conv_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic measStart,
   input wire logic [2:0] measChannel,
   input wire logic [3:0] latency,
   output logic measDone,
   output logic [15:0] measData
);
   logic [3:0] left;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         left <= 4'h0;
         measDone <= 1'b0;
         measData <= 16'h0000;
      end else if (left == 4'h1 && !measStart) begin
         left <= 4'h0;
         measDone <= 1'b1;
         measData <= 16'h1234 + 16'h1111 * {13'h0000, measChannel};
      end else begin
         // Data is only valid with done, so it toggles otherwise
         left <= measStart ? latency : ((left == 4'h0) ? 4'h0 : left - 4'h1);
         measDone <= 1'b0;
         measData <= ~measData;
      end
   end
endmodule : ams_conv_model

// ---- tb/ams_scheduler_tb.sv ----
// Scheduler bench
`timescale 1ns/1ps
module ams_scheduler_tb;
   import ams_pkg::*;
   typedef struct {logic [7:0] channel_enable_list; logic [7:0] cmd; logic [17:0] seq; int n;
      logic [7:0] flags;} ams_row_t;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [5:0] regAddr = 6'h00;
   logic [7:0] regWdata = 8'h00;
   logic [7:0] regRdata;
   logic measStart;
   logic [2:0] measChannel;
   logic measDone;
   logic [15:0] measData;
   logic seqAwake;
   logic intAsserted;
   logic [3:0] latency = 4'h2;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [2:0] chq[$];
   int tq[$];
   logic sawLow = 1'b0;
   logic sawHigh = 1'b0;
   logic [7:0] r, r0, lo, hi;
   ams_row_t rows[4] = '{
      '{8'h07, CMD_PS_FORCE, {3'h0, 3'h0, 3'h0, 3'h5, 3'h4, 3'h3}, 3, 8'h04},
      '{8'h70, CMD_ALS_FORCE, {3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0}, 3, 8'h01},
      '{8'h75, CMD_BOTH_FORCE, {3'h0, 3'h2, 3'h1, 3'h0, 3'h5, 3'h3}, 5, 8'h05},
      '{8'h52, CMD_BOTH_FORCE, {3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h4}, 3, 8'h05}};
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (measStart) begin
         chq.push_back(measChannel);
         tq.push_back(cyc);
      end
      if (seqAwake) begin
         sawHigh <= 1'b1;
      end else begin
         sawLow <= 1'b1;
      end
   end
   ams_scheduler #(.WAKE_BASE(4)) dut_u (.core_clk(core_clk), .rstn(rstn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .measStart(measStart), .measChannel(measChannel), .measDone(measDone),
      .measData(measData), .seqAwake(seqAwake), .intAsserted(intAsserted));
   ams_conv_model conv_u (.core_clk(core_clk), .rstn(rstn), .measStart(measStart),
      .measChannel(measChannel), .latency(latency), .measDone(measDone), .measData(measData));
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   task automatic waitchg(input logic [7:0] prev, output logic [7:0] resp);
      int k;
      k = 0;
      resp = prev;
      while (resp === prev && k < 400) begin
         rd(REG_RESPONSE, resp);
         k++;
      end
      chk(resp[7:4], 4'h0);
   endtask : waitchg
   task automatic cmd(input logic [7:0] c, output logic [7:0] resp);
      wr(REG_COMMAND, CMD_NOP);
      repeat (6) @(posedge core_clk);
      rd(REG_RESPONSE, resp);
      chk(resp, 8'h00);
      wr(REG_COMMAND, c);
      waitchg(8'h00, resp);
   endtask : cmd
   task automatic setp(input logic [4:0] a, input logic [7:0] v);
      logic [7:0] x;
      wr(REG_PARAM_WR, v);
      cmd({OP_SET, a}, x);
   endtask : setp
   task automatic waitq(input int n, input int lim);
      int k;
      k = 0;
      while (chq.size() < n && k < lim) begin
         @(posedge core_clk);
         k++;
      end
      chk(18'(chq.size() >= n), 18'h1);
   endtask : waitq
   function automatic logic [17:0] packq();
      logic [17:0] p;
      p = '0;
      for (int i = 0; i < chq.size() && i < 6; i++) begin
         p[3*i +: 3] = chq[i];
      end
      return p;
   endfunction : packq
   task automatic wrap_up();
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      wr(REG_IRQ_ENABLE, 8'h05);
      foreach (rows[i]) begin
         setp(PARAM_CHANNEL_LIST, rows[i].channel_enable_list);
         chq.delete();
         cmd(rows[i].cmd, r);
         chk(18'(chq.size()), 18'(rows[i].n));
         chk(packq(), rows[i].seq);
         foreach (chq[j]) begin
            rd(REG_RESULT_BASE + {2'h0, chq[j], 1'b0}, lo);
            rd(REG_RESULT_BASE + {2'h0, chq[j], 1'b1}, hi);
            chk({hi, lo}, 16'h1234 + 16'h1111 * {13'h0000, chq[j]});
         end
         chk(intAsserted, 1'b1);
         rd(REG_IRQ_FLAGS, r);
         chk(r, rows[i].flags);
         wr(REG_IRQ_FLAGS, 8'hff);
         @(posedge core_clk);
         #1 chk(intAsserted, 1'b0);
      end
      // Plain accesses must not wake
      sawHigh = 1'b0;
      rd(REG_RESPONSE, r0);
      wr(REG_RESPONSE, 8'hff);
      wr(REG_PS_THRESH_LO, 8'h10);
      rd(REG_RESPONSE, r);
      chk(r, r0);
      rd(6'h3f, r);
      chk(r, 8'h00);
      rd(REG_SEQ_STATE, r);
      chk(r, SEQ_READY);
      chk(sawHigh, 1'b0);
      cmd({OP_QUERY, PARAM_PS_DIVIDER}, r0);
      rd(REG_PARAM_RD, r);
      chk(r, DIVIDER_RESET);
      for (int i = 0; i < 17; i++) begin
         wr(REG_COMMAND, {OP_QUERY, PARAM_PS_DIVIDER});
         waitchg(r0, r);
         chk(r, {4'h0, r0[3:0] + 4'h1});
         r0 = r;
      end
      // Autonomous: proximity every wake, ambient every second wake
      setp(PARAM_CHANNEL_LIST, 8'h11);
      setp(PARAM_PS_DIVIDER, 8'h01);
      setp(PARAM_ALS_DIVIDER, 8'h02);
      wr(REG_WAKE_INTERVAL, 8'h28);
      chq.delete();
      tq.delete();
      cmd(CMD_BOTH_LOOP, r);
      sawLow = 1'b0;
      waitq(6, 1200);
      chk(packq(), {3'h3, 3'h0, 3'h3, 3'h3, 3'h0, 3'h3});
      chk(18'(tq[2] - tq[0]), 18'd160);
      chk(18'(tq[3] - tq[2]), 18'd160);
      chk(sawLow, 1'b1);
      wr(REG_WAKE_INTERVAL, 8'h00);
      repeat (320) @(posedge core_clk);
      chq.delete();
      repeat (400) @(posedge core_clk);
      chk(18'(chq.size()), 18'd0);
      cmd(CMD_BOTH_PAUSE, r);
      // No-sleep, slow converter, ambient off, proximity every third wake
      setp(PARAM_NO_SLEEP, NO_SLEEP_ON);
      setp(PARAM_PS_DIVIDER, 8'h03);
      setp(PARAM_ALS_DIVIDER, 8'h00);
      wr(REG_WAKE_INTERVAL, 8'h28);
      latency = 4'h9;
      chq.delete();
      tq.delete();
      cmd(CMD_BOTH_LOOP, r);
      sawLow = 1'b0;
      waitq(3, 1600);
      chk(packq(), {9'h000, 3'h3, 3'h3, 3'h3});
      chk(18'(tq[1] - tq[0]), 18'd480);
      chk(sawLow, 1'b0);
      wr(REG_WAKE_INTERVAL, 8'h00);
      repeat (960) @(posedge core_clk);
      setp(PARAM_NO_SLEEP, NO_SLEEP_OFF);
      cmd(CMD_BOTH_PAUSE, r);
      repeat (4) @(posedge core_clk);
      #1 chk(seqAwake, 1'b0);
      // Reset in the middle of a forced conversion
      wr(REG_WAKE_INTERVAL, 8'h28);
      wr(REG_COMMAND, CMD_BOTH_FORCE);
      repeat (6) @(posedge core_clk);
      rstn <= 1'b0;
      @(posedge core_clk);
      #1 chk({measStart, seqAwake, intAsserted, regRdata}, 11'h000);
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      chq.delete();
      rd(REG_WAKE_INTERVAL, r);
      chk(r, WAKE_INTERVAL_RESET);
      rd(REG_RESPONSE, r);
      chk(r, 8'h00);
      repeat (300) @(posedge core_clk);
      chk(18'(chq.size()), 18'd0);
      wrap_up();
   end
endmodule : ams_scheduler_tb
bind ams_scheduler ams_monitor mon_u (.core_clk(core_clk), .rstn(rstn), .regWrite(regWrite),
   .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .measStart(measStart), .measChannel(measChannel), .measDone(measDone),
   .measData(measData), .seqAwake(seqAwake), .intAsserted(intAsserted));
